// ===== verilog/cbx_consts.svh
// Purpose: Constants for the conditional branch and bit clear executor
// Assumes: Included by bare name; definitions only
// Notes:   Offsets are APB byte addresses, one aligned 32-bit word each
`ifndef CBX_CONSTS_SVH
`define CBX_CONSTS_SVH

// ----------------------------------------------------------------
// Opcode decode
// ----------------------------------------------------------------
`define OPC_BRANCH_IF_CARRY_SET      8'hE2
`define OPC_BRANCH_IF_NEGATIVE       8'hE6
`define OPC_BRANCH_IF_CARRY_CLEAR    8'hE3
`define OPC_BRANCH_IF_NOT_NEGATIVE   8'hE7
`define OPC_BRANCH_IF_NO_OVERFLOW    8'hE5
`define OPC_BRANCH_IF_NONZERO        8'hE1
`define OPC_FILE_BIT_CLEAR           4'h9

// ----------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------
`define FLD_HIGH_BYTE_MSB            15
`define FLD_HIGH_BYTE_LSB            8
`define FLD_TOP_NIBBLE_LSB           12
`define FLD_BIT_IDX_MSB              11
`define FLD_BIT_IDX_LSB              9
`define FLD_ACCESS_FLAG              8
`define FLD_LOW_BYTE_MSB             7
`define ACCESS_BANK                  4'h0

// ----------------------------------------------------------------
// Register map and reset values
// ----------------------------------------------------------------
`define REG_CTRL                     8'h00
`define REG_BANK                     8'h04
`define REG_STATUS                   8'h08
`define REG_LAST_TARGET              8'h0C
`define REG_CNT_TAKEN                8'h10
`define REG_CNT_UNTAKEN              8'h14
`define REG_CNT_CLEAR                8'h18
`define CTRL_EN_BIT                  0
`define CTRL_CNT_RST_BIT             1
`define CTRL_EN_RST                  1'b1
`define BANK_RST                     4'h0
`define PC_WIDTH_DEF                 21

`endif

// ===== verilog/cbx_pkg.sv
// Purpose: Types shared by the executor and its phase generator
// Assumes: Nothing beyond the language
// Notes:   Constants live in cbx_consts.svh
package cbx_pkg;

   typedef enum logic [1:0] {Q1, Q2, Q3, Q4} qphase_t;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_BRANCH_IF_CARRY_SET,
      OP_BRANCH_IF_NEGATIVE,
      OP_BRANCH_IF_CARRY_CLEAR,
      OP_BRANCH_IF_NOT_NEGATIVE,
      OP_BRANCH_IF_NO_OVERFLOW,
      OP_BRANCH_IF_NONZERO,
      OP_FILE_BIT_CLEAR
   } op_t;

endpackage

// ===== verilog/qphase_gen.sv
// Purpose: Quarter-phase sequencer, one phase per pclk
// Assumes: Free-running core clock
// Notes:   Starts in Q1 after reset release
`timescale 1ns/1ns
module qphase_gen import cbx_pkg::*; (
   input  wire logic    pclk,
   input  wire logic    presetn,
   output qphase_t      phase
);

   typedef struct packed {
      qphase_t phase;
   } qstate_t;

   qstate_t st_r;
   qstate_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      unique case (st_r.phase)
         Q1: st_nxt.phase = Q2;
         Q2: st_nxt.phase = Q3;
         Q3: st_nxt.phase = Q4;
         Q4: st_nxt.phase = Q1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '{phase: Q1};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign phase = st_r.phase;

endmodule

// ===== verilog/cond_branch_bit_clear_exec.sv
// Purpose: Decode and execute of six conditional branches and file bit clear
// Assumes: Instruction word and its address valid during Q1; memory read
//          data valid during Q3 for the read strobed on mem_rd in that same Q3
// Notes:   Status flags are only read here, never written
`timescale 1ns/1ns
`include "cbx_consts.svh"
module cond_branch_bit_clear_exec import cbx_pkg::*; #(
   parameter int PC_W = `PC_WIDTH_DEF
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [15:0]       instr_word,
   input  wire logic [PC_W-1:0]   instr_addr,
   input  wire logic              flag_carry,
   input  wire logic              flag_negative,
   input  wire logic              flag_overflow,
   input  wire logic              flag_zero,
   output logic                   pc_load,
   output logic      [PC_W-1:0]   pc_value,
   output logic                   nop_cycle,
   output qphase_t                phase,
   output logic                   mem_rd,
   output logic                   mem_wr,
   output logic      [11:0]       mem_addr,
   output logic      [7:0]        mem_wdata,
   input  wire logic [7:0]        mem_rdata
);

   if (PC_W < 10 || PC_W > 32) begin : g_pc_w_check
      $error("PC_W must lie between 10 and 32");
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic op_t decode_op(input logic [15:0] w);
      logic [7:0] hi;
      hi = w[`FLD_HIGH_BYTE_MSB:`FLD_HIGH_BYTE_LSB];
      if (w[`FLD_HIGH_BYTE_MSB:`FLD_TOP_NIBBLE_LSB] == `OPC_FILE_BIT_CLEAR) begin
         return OP_FILE_BIT_CLEAR;
      end
      unique case (hi)
         `OPC_BRANCH_IF_CARRY_SET:    return OP_BRANCH_IF_CARRY_SET;
         `OPC_BRANCH_IF_NEGATIVE:     return OP_BRANCH_IF_NEGATIVE;
         `OPC_BRANCH_IF_CARRY_CLEAR:  return OP_BRANCH_IF_CARRY_CLEAR;
         `OPC_BRANCH_IF_NOT_NEGATIVE: return OP_BRANCH_IF_NOT_NEGATIVE;
         `OPC_BRANCH_IF_NO_OVERFLOW:  return OP_BRANCH_IF_NO_OVERFLOW;
         `OPC_BRANCH_IF_NONZERO:      return OP_BRANCH_IF_NONZERO;
         default:                     return OP_NONE;
      endcase
   endfunction

   function automatic logic branch_taken(input op_t op, input logic c,
                                         input logic n, input logic ov,
                                         input logic z);
      logic t;
      t = 1'b0;
      unique case (op)
         OP_BRANCH_IF_CARRY_SET:    t = c;
         OP_BRANCH_IF_NEGATIVE:     t = n;
         OP_BRANCH_IF_CARRY_CLEAR:  t = ~c;
         OP_BRANCH_IF_NOT_NEGATIVE: t = ~n;
         OP_BRANCH_IF_NO_OVERFLOW:  t = ~ov;
         OP_BRANCH_IF_NONZERO:      t = ~z;
         OP_NONE, OP_FILE_BIT_CLEAR: t = 1'b0;
      endcase
      return t;
   endfunction

   function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] base,
                                                     input logic [7:0] n);
      logic [PC_W-1:0] soff;
      soff = PC_W'({{(PC_W-9){n[7]}}, n, 1'b0});
      return base + PC_W'(2) + soff;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      op_t              op;
      logic [7:0]       offs;
      logic [PC_W-1:0]  iaddr;
      logic [2:0]       bit_idx;
      logic             acc;
      logic [7:0]       faddr;
      logic             squash;
      logic             squash_next;
      logic             mem_rd;
      logic             mem_wr;
      logic [11:0]      mem_addr;
      logic [7:0]       mem_wdata;
      logic             pc_load;
      logic [PC_W-1:0]  pc_value;
      logic             last_taken;
      logic             en;
      logic [3:0]       bsel;
      logic [15:0]      cnt_taken;
      logic [15:0]      cnt_untaken;
      logic [15:0]      cnt_clear;
      logic [31:0]      prdata;
   } exec_state_t;

   exec_state_t st_r;
   exec_state_t st_nxt;
   qphase_t     q;
   logic        apb_wr;
   logic        apb_setup;
   logic        addr_ok;
   logic        taken_now;

   qphase_gen u_qphase (
      .pclk    (pclk),
      .presetn (presetn),
      .phase   (q)
   );

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   always_comb begin
      unique case (paddr)
         `REG_CTRL, `REG_BANK, `REG_STATUS, `REG_LAST_TARGET,
         `REG_CNT_TAKEN, `REG_CNT_UNTAKEN, `REG_CNT_CLEAR: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   assign apb_setup = psel & ~penable;
   assign apb_wr    = psel & penable & pwrite & addr_ok;
   assign taken_now = branch_taken(st_r.op, flag_carry, flag_negative,
                                   flag_overflow, flag_zero);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt         = st_r;
      st_nxt.mem_rd  = 1'b0;
      st_nxt.mem_wr  = 1'b0;
      st_nxt.pc_load = 1'b0;

      unique case (q)
         Q1: begin
            // prefetched word discarded after taken branch
            if (st_r.squash || !st_r.en) begin
               st_nxt.op = OP_NONE;
            end else begin
               st_nxt.op = decode_op(instr_word);
            end
            st_nxt.offs    = instr_word[`FLD_LOW_BYTE_MSB:0];
            st_nxt.iaddr   = instr_addr;
            st_nxt.bit_idx = instr_word[`FLD_BIT_IDX_MSB:`FLD_BIT_IDX_LSB];
            st_nxt.acc     = instr_word[`FLD_ACCESS_FLAG];
            st_nxt.faddr   = instr_word[`FLD_LOW_BYTE_MSB:0];
         end
         Q2: begin
            if (st_r.op == OP_FILE_BIT_CLEAR) begin
               st_nxt.mem_rd = 1'b1;
               st_nxt.mem_addr = {st_r.acc ? st_r.bsel : `ACCESS_BANK, st_r.faddr};
            end
         end
         Q3: begin
            if (st_r.op == OP_FILE_BIT_CLEAR) begin
               st_nxt.mem_wdata = mem_rdata & ~(8'h01 << st_r.bit_idx);
               st_nxt.mem_wr    = 1'b1;
            end else if (st_r.op != OP_NONE) begin
               st_nxt.last_taken = taken_now;
               if (taken_now) begin
                  st_nxt.pc_load  = 1'b1;
                  st_nxt.pc_value = branch_target(st_r.iaddr, st_r.offs);
               end
               st_nxt.squash_next = taken_now;
               if (taken_now) begin
                  st_nxt.cnt_taken = st_r.cnt_taken + 16'h0001;
               end else begin
                  st_nxt.cnt_untaken = st_r.cnt_untaken + 16'h0001;
               end
            end
            if (st_r.op == OP_FILE_BIT_CLEAR) begin
               st_nxt.cnt_clear = st_r.cnt_clear + 16'h0001;
            end
         end
         Q4: begin
            st_nxt.squash      = st_r.squash_next;
            st_nxt.squash_next = 1'b0;
         end
      endcase

      // Writes from software; a counter clear with a same-cycle count leaves that counter at 1
      if (apb_wr) begin
         unique case (paddr)
            `REG_CTRL: begin
               st_nxt.en = pwdata[`CTRL_EN_BIT];
               if (pwdata[`CTRL_CNT_RST_BIT]) begin
                  if (st_nxt.cnt_taken == st_r.cnt_taken) begin
                     st_nxt.cnt_taken = 16'h0000;
                  end else begin
                     st_nxt.cnt_taken = 16'h0001;
                  end
                  if (st_nxt.cnt_untaken == st_r.cnt_untaken) begin
                     st_nxt.cnt_untaken = 16'h0000;
                  end else begin
                     st_nxt.cnt_untaken = 16'h0001;
                  end
                  if (st_nxt.cnt_clear == st_r.cnt_clear) begin
                     st_nxt.cnt_clear = 16'h0000;
                  end else begin
                     st_nxt.cnt_clear = 16'h0001;
                  end
               end
            end
            `REG_BANK: st_nxt.bsel = pwdata[3:0];
            default: ;
         endcase
      end

      // Read data captured in setup so it is stable through access
      if (apb_setup) begin
         unique case (paddr)
            `REG_CTRL:        st_nxt.prdata = {31'h0, st_r.en};
            `REG_BANK:        st_nxt.prdata = {28'h0, st_r.bsel};
            `REG_STATUS:      st_nxt.prdata = {27'h0, st_r.op == OP_FILE_BIT_CLEAR,
                                               st_r.squash_next, st_r.last_taken,
                                               st_r.squash, st_r.op != OP_NONE};
            `REG_LAST_TARGET: st_nxt.prdata = 32'(st_r.pc_value);
            `REG_CNT_TAKEN:   st_nxt.prdata = {16'h0, st_r.cnt_taken};
            `REG_CNT_UNTAKEN: st_nxt.prdata = {16'h0, st_r.cnt_untaken};
            `REG_CNT_CLEAR:   st_nxt.prdata = {16'h0, st_r.cnt_clear};
            default:          st_nxt.prdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.op          <= OP_NONE;
         st_r.offs        <= 8'h00;
         st_r.iaddr       <= '0;
         st_r.bit_idx     <= 3'h0;
         st_r.acc         <= 1'b0;
         st_r.faddr       <= 8'h00;
         st_r.squash      <= 1'b0;
         st_r.squash_next <= 1'b0;
         st_r.mem_rd      <= 1'b0;
         st_r.mem_wr      <= 1'b0;
         st_r.mem_addr    <= 12'h000;
         st_r.mem_wdata   <= 8'h00;
         st_r.pc_load     <= 1'b0;
         st_r.pc_value    <= '0;
         st_r.last_taken  <= 1'b0;
         st_r.en          <= `CTRL_EN_RST;
         st_r.bsel        <= `BANK_RST;
         st_r.cnt_taken   <= 16'h0000;
         st_r.cnt_untaken <= 16'h0000;
         st_r.cnt_clear   <= 16'h0000;
         st_r.prdata      <= 32'h0000_0000;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Zero-wait slave: every access completes in its first access cycle
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~addr_ok;
   assign prdata    = st_r.prdata;
   assign pc_load   = st_r.pc_load;
   assign pc_value  = st_r.pc_value;
   assign nop_cycle = st_r.squash;
   assign phase     = q;
   assign mem_rd    = st_r.mem_rd;
   assign mem_wr    = st_r.mem_wr;
   assign mem_addr  = st_r.mem_addr;
   assign mem_wdata = st_r.mem_wdata;

endmodule

// ===== bench/cbx_mem_model.sv
// Purpose: Banked data memory seen by the executor
// Assumes: Read answered in the same cycle as mem_rd
// Notes:   Byte i starts as its low index bits xor 5A
`timescale 1ns/1ns
module cbx_mem_model (
   input  wire logic        pclk,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic [11:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output logic      [7:0]  mem_rdata
);
   logic [7:0] mem [0:4095];
   logic [7:0] last_r;
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
      last_r = 8'h00;
   end
   always @(posedge pclk) begin
      if (mem_rd) last_r <= mem[mem_addr];
      if (mem_wr) mem[mem_addr] <= mem_wdata;
   end
   // Idle bus shows the inverse, so a stale read cannot pass
   assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_r;
endmodule

// ===== bench/cbx_chk.sv
// Purpose: Port assertions for the executor
// Assumes: Word shown in Q1, flags held to Q3
// Notes:   Bound to the executor at the foot
`timescale 1ns/1ns
module cbx_chk import cbx_pkg::*; #(parameter int PC_W = 21) (
   input wire logic            pclk,
   input wire logic            presetn,
   input wire logic [15:0]     instr_word,
   input wire logic [PC_W-1:0] instr_addr,
   input wire logic            flag_carry,
   input wire logic            flag_negative,
   input wire logic            flag_overflow,
   input wire logic            flag_zero,
   input wire logic            pc_load,
   input wire logic [PC_W-1:0] pc_value,
   input wire logic            nop_cycle,
   input wire qphase_t         phase,
   input wire logic            mem_rd,
   input wire logic            mem_wr,
   input wire logic [11:0]     mem_addr,
   input wire logic [7:0]      mem_wdata,
   input wire logic [7:0]      mem_rdata
);
   // ------------
   // Capture
   // ------------
   logic [15:0]     word_r;
   logic [PC_W-1:0] addr_r;
   logic [3:0]      flg_r;
   logic            take_ok;
   logic [PC_W-1:0] tgt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_r <= 16'h0000;
         addr_r <= '0;
         flg_r <= 4'h0;
      end else begin
         if (phase == Q1) begin
            word_r <= instr_word;
            addr_r <= instr_addr;
         end
         if (phase == Q3) begin
            flg_r <= {flag_carry, flag_negative, flag_overflow, flag_zero};
         end
      end
   end
   always_comb begin
      case (word_r[15:8])
         8'hE2:   take_ok = flg_r[3];
         8'hE6:   take_ok = flg_r[2];
         8'hE3:   take_ok = !flg_r[3];
         8'hE7:   take_ok = !flg_r[2];
         8'hE5:   take_ok = !flg_r[1];
         8'hE1:   take_ok = !flg_r[0];
         default: take_ok = 1'b0;
      endcase
   end
   assign tgt = addr_r + PC_W'(2) + PC_W'({{(PC_W-8){word_r[7]}}, word_r[7:0], 1'b0});
   // ------------
   // Properties
   // ------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   take_cond_a: assert property (pc_load |-> take_ok)
      else $error("branch taken against flags");
   load_phase_a: assert property (pc_load |-> phase == Q4)
      else $error("pc load outside Q4");
   load_target_a: assert property (pc_load |-> pc_value == tgt)
      else $error("wrong branch target");
   nop_follow_a: assert property (pc_load |=> nop_cycle [*4] ##1 !nop_cycle)
      else $error("no single nop cycle after branch");
   nop_quiet_a: assert property (nop_cycle |-> !pc_load && !mem_rd && !mem_wr)
      else $error("activity in nop cycle");
   clr_seq_a: assert property (mem_rd |-> phase == Q3 ##1 (mem_wr && phase == Q4))
      else $error("bit clear strobe order");
   clr_data_a: assert property (mem_wr |->
      mem_wdata == ($past(mem_rdata) & ~(8'h01 << word_r[11:9])))
      else $error("bit clear data");
   clr_decode_a: assert property (mem_rd |-> word_r[15:12] == 4'h9)
      else $error("memory read without bit clear");
   access_bank_a: assert property (mem_rd && !word_r[8] |->
      mem_addr == {4'h0, word_r[7:0]})
      else $error("access bank not used");
   file_addr_a: assert property (mem_rd |-> mem_addr[7:0] == word_r[7:0])
      else $error("file address wrong");
   cover property (pc_load);
   cover property (mem_wr && word_r[8]);
   cover property (mem_rd && !word_r[8]);
endmodule
bind cond_branch_bit_clear_exec cbx_chk #(.PC_W(PC_W)) chk_i (
   .pclk(pclk), .presetn(presetn), .instr_word(instr_word), .instr_addr(instr_addr),
   .flag_carry(flag_carry), .flag_negative(flag_negative), .flag_overflow(flag_overflow),
   .flag_zero(flag_zero), .pc_load(pc_load), .pc_value(pc_value), .nop_cycle(nop_cycle),
   .phase(phase), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
   .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
);

// ===== bench/cond_branch_bit_clear_exec_tb.sv
// Purpose: Self-checking bench for the executor
// Assumes: Memory model answers in Q3
// Notes:   Words shown in Q1 only, else 0000
`timescale 1ns/1ns
`include "cbx_consts.svh"
module cond_branch_bit_clear_exec_tb import cbx_pkg::*;;
   localparam int            PW   = `PC_WIDTH_DEF;
   localparam logic [PW-1:0] BASE = 21'h001000;
   logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]    paddr, mem_wdata, mem_rdata;
   logic [31:0]   pwdata, prdata;
   logic [15:0]   instr_word;
   logic [PW-1:0] instr_addr, pc_value;
   logic          flag_carry, flag_negative, flag_overflow, flag_zero;
   logic          pc_load, nop_cycle, mem_rd, mem_wr;
   logic [11:0]   mem_addr;
   qphase_t       phase;
   int            err_count, samples_checked;
   cond_branch_bit_clear_exec #(.PC_W(PW)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_word(instr_word), .instr_addr(instr_addr), .flag_carry(flag_carry),
      .flag_negative(flag_negative), .flag_overflow(flag_overflow), .flag_zero(flag_zero),
      .pc_load(pc_load), .pc_value(pc_value), .nop_cycle(nop_cycle), .phase(phase),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata)
   );
   cbx_mem_model mem_i (
      .pclk(pclk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
   );
   // ------------
   // Helpers
   // ------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("Checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic fail_wait();
      err_count++;
      $display("Wait limit reached at t=%0t", $time);
      results();
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
         if (i == 15) fail_wait();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic sync();
      for (int i = 0; i < 8; i++) begin
         @(negedge pclk);
         if (phase === Q4) return;
      end
      fail_wait();
   endtask
   // Runs one instruction cycle, plus the nop cycle after a taken branch
   task automatic exec(input logic [15:0] w, input logic [3:0] f, input logic tk,
                       input logic clr, input logic [11:0] ma);
      logic [PW-1:0] tgt;
      logic [7:0]    wd;
      tgt = BASE + PW'(2) + PW'($signed(w[7:0])) * PW'(2);
      wd = (w[7:0] ^ 8'h5A) & ~(8'h01 << w[11:9]);
      @(posedge pclk);
      instr_word <= w;
      instr_addr <= BASE;
      {flag_carry, flag_negative, flag_overflow, flag_zero} <= f;
      @(posedge pclk);
      instr_word <= 16'h0000;
      @(negedge pclk);
      @(negedge pclk);
      chk(mem_rd, clr);
      if (clr) chk(mem_addr, ma);
      @(negedge pclk);
      chk(pc_load, tk);
      if (tk) chk(pc_value, tgt);
      chk(mem_wr, clr);
      if (clr) chk(mem_wdata, wd);
      if (tk) begin
         @(posedge pclk);
         instr_word <= 16'h9F33;
         @(posedge pclk);
         instr_word <= 16'h0000;
         @(negedge pclk);
         chk(nop_cycle, 1'b1);
         @(negedge pclk);
         @(negedge pclk);
         chk(mem_wr, 1'b0);
         chk(pc_load, 1'b0);
      end
   endtask
   // ------------
   // Scenarios
   // ------------
   task automatic t_regs();
      logic [31:0] rd;
      logic        er;
      apb(1'b0, `REG_CTRL, 32'h0, rd, er);
      chk(rd, 32'h1);
      apb(1'b1, `REG_BANK, 32'h5, rd, er);
      apb(1'b0, `REG_BANK, 32'h0, rd, er);
      chk(rd, 32'h5);
      apb(1'b0, 8'h40, 32'h0, rd, er);
      chk(rd, 32'h0);
      chk(er, 1'b1);
      $display("register test done");
   endtask
   task automatic t_branches();
      logic [7:0] ops [6] = '{`OPC_BRANCH_IF_CARRY_SET, `OPC_BRANCH_IF_NEGATIVE,
         `OPC_BRANCH_IF_CARRY_CLEAR, `OPC_BRANCH_IF_NOT_NEGATIVE,
         `OPC_BRANCH_IF_NO_OVERFLOW, `OPC_BRANCH_IF_NONZERO};
      logic [7:0] offs [6] = '{8'h80, 8'h7F, 8'hFF, 8'h00, 8'h01, 8'hC0};
      int         pos [6] = '{3, 2, 3, 2, 1, 0};
      logic       need [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      logic [3:0] f;
      sync();
      for (int i = 0; i < 6; i++) begin
         for (int s = 0; s < 2; s++) begin
            f = s[0] ? 4'h1 << pos[i] : ~(4'h1 << pos[i]);
            exec({ops[i], offs[i]}, f, s[0] == need[i], 1'b0, 12'h000);
         end
      end
      $display("branch test done");
   endtask
   task automatic t_bitclr();
      sync();
      exec(16'hE3FE, 4'h0, 1'b1, 1'b0, 12'h000);
      exec(16'h9EA5, 4'hF, 1'b0, 1'b1, 12'h0A5);
      exec(16'h9045, 4'h0, 1'b0, 1'b1, 12'h045);
      exec(16'h9781, 4'hA, 1'b0, 1'b1, 12'h581);
      exec(16'hE011, 4'hF, 1'b0, 1'b0, 12'h000);
      exec(16'h8E21, 4'h0, 1'b0, 1'b0, 12'h000);
      $display("bit clear test done");
   endtask
   // Counts follow the earlier scenarios: 7 taken, 6 untaken, 3 clears
   task automatic t_ctrl();
      logic [31:0] rd;
      logic        er;
      apb(1'b0, `REG_CNT_TAKEN, 32'h0, rd, er);
      chk(rd, 32'h0000_0007);
      chk(er, 1'b0);
      apb(1'b0, `REG_CNT_UNTAKEN, 32'h0, rd, er);
      chk(rd, 32'h0000_0006);
      apb(1'b0, `REG_CNT_CLEAR, 32'h0, rd, er);
      chk(rd, 32'h0000_0003);
      apb(1'b0, `REG_LAST_TARGET, 32'h0, rd, er);
      chk(rd, 32'h0000_0FFE);
      apb(1'b1, `REG_CTRL, 32'h0, rd, er);
      sync();
      exec(16'hE210, 4'h8, 1'b0, 1'b0, 12'h000);
      exec(16'h9F10, 4'h0, 1'b0, 1'b0, 12'h000);
      apb(1'b1, `REG_CTRL, 32'h3, rd, er);
      apb(1'b0, `REG_CNT_TAKEN, 32'h0, rd, er);
      chk(rd, 32'h0000_0000);
      apb(1'b0, `REG_CNT_CLEAR, 32'h0, rd, er);
      chk(rd, 32'h0000_0000);
      apb(1'b0, `REG_CTRL, 32'h0, rd, er);
      chk(rd, 32'h0000_0001);
      $display("control test done");
   endtask
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      instr_word = 16'h0000;
      instr_addr = '0;
      {flag_carry, flag_negative, flag_overflow, flag_zero} = 4'h0;
      err_count = 0;
      samples_checked = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_branches();
      t_bitclr();
      t_ctrl();
      results();
   end
endmodule
